// *** core/otp_dev.sv ***
// Purpose: device end; decodes OTP lock and mode commands
// Assumes: host frames whole bytes, sck half period of several clocks
// Notes: main array lives elsewhere; its writes leave as strobes
// Behaviour
// - security write needs no write enable
// - security write may set customer lock bit1
// - customer lock refuses all OTP programming
// - set lock bits never clear again
// - security write needs byte-aligned deselect
// - security bit0 reports factory lock
// - enter, program, exit OTP mode sequence
// - OTP mode blocks main array writes
// - OTP 000000-00000F is serial number region
// - OTP 000010-0001FF is customer data region
// - delivered array bytes read FFh
// - delivered status bits read zero
// - accel voltage allows only status read, program
// - accel program start address 4-byte aligned
// - accel program data multiples of four bytes
// - host waits settle time after accel change
// - writes ignored during power-up delay
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module otp_dev
	import otp_pkg::*;
#(
	parameter int PUW_CYC = PUW_MIN_CYC,
	parameter logic FACTORY_LOCKED = 1'b0
) (
	input wire logic clock,
	input wire logic srst,
	otp_link_if.dev link,
	output logic otp_mode,
	output logic cust_lock,
	output logic fact_lock,
	output logic write_inhibit,
	output logic cmd_rejected,
	output logic main_wr,
	output logic [23:0] main_addr,
	output logic [7:0] main_data
);
	typedef struct packed {
		logic sck_d;
		logic cs_d;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] sr;
		logic [7:0] dat;
		logic [7:0] op;
		logic [23:0] addr;
		logic [7:0] out_sr;
		logic miso;
		logic wel;
		logic otp_mode;
		logic cust_lock;
		logic [19:0] pu_cnt;
		logic pu_done;
		logic rej;
		logic main_wr;
		logic [23:0] main_addr;
		logic [7:0] main_data;
	} otp_dev_st_t;
	localparam otp_dev_st_t DEV_RST = '{cs_d: 1'b1, default: '0};

	otp_dev_st_t s;
	otp_dev_st_t n;
	logic [7:0] otp_mem [0:OTP_BYTES-1];
	logic [3:0] pins;
	logic cs_s;
	logic sck_s;
	logic mosi_s;
	logic accel_s;
	logic [7:0] nsr;
	logic [7:0] stat;
	logic [7:0] sec;
	logic whole;
	logic locked;
	logic mem_we;
	logic [8:0] mem_wa;
	logic [7:0] mem_wd;

	otp_sync #(.W(4)) u_sync (
		.clock(clock),
		.srst(srst),
		.d({!link.cs_n, link.sck, link.mosi, link.accel_hv}), // Select inverted: reset reads idle
		.q(pins)
	);
	assign {cs_s, sck_s, mosi_s, accel_s} = {!pins[3], pins[2:0]};

	// Array read; outside OTP mode the main array is not here
	function automatic logic [7:0] rd_byte(input logic [23:0] a);
		if (s.otp_mode && a <= OTP_LAST) begin
			return otp_mem[a[8:0]];
		end
		return ERASED_BYTE;
	endfunction

	// Opcode gate applied when the first byte lands
	function automatic logic op_ok(input logic [7:0] op);
		if (accel_s) begin
			return accel_op(op) && (op != OP_PP || s.wel);
		end
		if (is_write_op(op) && !s.pu_done) begin
			return 1'b0;
		end
		if (op == OP_PP) begin
			return s.wel;
		end
		return 1'b1;
	endfunction

	always_comb begin
		n = s;
		n.rej = 1'b0;
		n.main_wr = 1'b0;
		n.sck_d = sck_s;
		n.cs_d = cs_s;
		mem_we = 1'b0;
		mem_wa = s.addr[8:0];
		mem_wd = ERASED_BYTE;
		nsr = {s.sr[6:0], mosi_s};
		stat = '0;
		stat[STAT_WEL_BIT] = s.wel;
		sec = '0;
		sec[SEC_FACT_BIT] = FACTORY_LOCKED;
		sec[SEC_CUST_BIT] = s.cust_lock;
		whole = s.bit_cnt == 3'h0;
		locked = s.cust_lock || FACTORY_LOCKED;
		// Power-up write inhibit timer
		if (!s.pu_done) begin
			n.pu_cnt = s.pu_cnt + 20'h1;
			if (s.pu_cnt == 20'(PUW_CYC - 1)) begin
				n.pu_done = 1'b1;
			end
		end
		if (cs_s) begin
			n.bit_cnt = '0;
			n.byte_cnt = '0;
		end
		// Deselect completes single-byte and security commands
		if (cs_s && !s.cs_d) begin
			unique case (s.op)
				OP_WREN: begin
					if (whole && s.byte_cnt == 3'h1) begin
						n.wel = 1'b1;
					end
				end
				OP_ENTER_OTP: begin
					if (whole && s.byte_cnt == 3'h1) begin
						n.otp_mode = 1'b1;
					end
				end
				OP_EXIT_OTP: begin
					if (whole && s.byte_cnt == 3'h1) begin
						n.otp_mode = 1'b0;
					end
				end
				OP_WRSEC: begin
					if (whole && s.byte_cnt == 3'h2) begin
						// OR keeps a set lock set; other data bits dropped
						n.cust_lock = s.cust_lock | s.dat[SEC_CUST_BIT];
					end else begin
						n.rej = 1'b1;
					end
				end
				OP_PP: begin
					n.wel = 1'b0;
				end
				default: begin
				end
			endcase
			n.op = OP_NONE;
		end
		// Rising sck: sample one bit
		if (!cs_s && sck_s && !s.sck_d) begin
			n.sr = nsr;
			n.bit_cnt = s.bit_cnt + 3'h1;
			if (s.bit_cnt == 3'h7) begin
				n.dat = nsr;
				if (s.byte_cnt != 3'h7) begin
					n.byte_cnt = s.byte_cnt + 3'h1;
				end
				if (s.byte_cnt == 3'h0) begin
					if (op_ok(nsr)) begin
						n.op = nsr;
					end else begin
						n.rej = 1'b1;
					end
					n.out_sr = (nsr == OP_RDSR) ? stat : sec;
				end else if (s.byte_cnt < 3'h4 && (s.op == OP_PP || s.op == OP_READ)) begin
					n.addr = {s.addr[15:0], nsr};
					n.out_sr = rd_byte({s.addr[15:0], nsr});
				end else begin
					unique case (s.op)
						OP_RDSR: n.out_sr = stat;
						OP_RDSEC: n.out_sr = sec;
						OP_READ: begin
							n.addr = s.addr + 24'h1;
							n.out_sr = rd_byte(s.addr + 24'h1);
						end
						OP_PP: begin
							// Address wraps inside the page
							n.addr = {s.addr[23:8], s.addr[7:0] + 8'h1};
							if (s.otp_mode) begin
								// Serial number and customer areas program alike
								if (locked || s.addr > OTP_LAST) begin
									n.rej = 1'b1;
								end else begin
									mem_we = 1'b1;
									mem_wd = nsr;
								end
							end else begin
								n.main_wr = 1'b1;
								n.main_addr = s.addr;
								n.main_data = nsr;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
		// Falling sck: present next output bit
		if (!cs_s && !sck_s && s.sck_d) begin
			n.miso = s.out_sr[7];
			n.out_sr = {s.out_sr[6:0], 1'b0};
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s <= DEV_RST;
		end else begin
			s <= n;
		end
	end

	// OTP cells only go from 1 to 0; reset stands for delivery state
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < OTP_BYTES; i++) begin
				otp_mem[i] <= ERASED_BYTE;
			end
		end else if (mem_we) begin
			otp_mem[mem_wa] <= otp_mem[mem_wa] & mem_wd;
		end
	end

	assign link.miso = s.miso;
	assign otp_mode = s.otp_mode;
	assign cust_lock = s.cust_lock;
	assign fact_lock = FACTORY_LOCKED;
	assign write_inhibit = !s.pu_done;
	assign cmd_rejected = s.rej;
	assign main_wr = s.main_wr;
	assign main_addr = s.main_addr;
	assign main_data = s.main_data;
endmodule
`default_nettype wire

// *** core/otp_pkg.sv ***
// Purpose: shared constants for the secured OTP lock control link
// Assumes: one 100 MHz clock on both ends
// Notes: opcodes, timing counts and host register map
package otp_pkg;
	localparam int CLK_MHZ = 100;
	// Power-up write delay window, in ms
	localparam int PUW_MIN_MS = 1;
	localparam int PUW_MAX_MS = 10;
	localparam int PUW_MIN_CYC = PUW_MIN_MS * 1000 * CLK_MHZ;
	localparam int PUW_MAX_CYC = PUW_MAX_MS * 1000 * CLK_MHZ;
	// Settling after accel voltage change, in us
	localparam int ACCEL_SETTLE_US = 5;
	localparam int ACCEL_SETTLE_CYC = ACCEL_SETTLE_US * CLK_MHZ;
	localparam logic [3:0] SCK_HALF_CYC = 4'h8;
	// Command opcodes
	localparam logic [7:0] OP_NONE = 8'h00;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_RDSEC = 8'h2b;
	localparam logic [7:0] OP_WRSEC = 8'h2f;
	localparam logic [7:0] OP_ENTER_OTP = 8'hb1;
	localparam logic [7:0] OP_EXIT_OTP = 8'hc1;
	// Security and status register fields
	localparam int SEC_FACT_BIT = 0;
	localparam int SEC_CUST_BIT = 1;
	localparam int STAT_WEL_BIT = 1;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// OTP map
	localparam int OTP_BYTES = 512;
	localparam logic [23:0] ESN_LAST = 24'h00000f;
	localparam logic [23:0] OTP_LAST = 24'h0001ff;
	// Host register map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0c;
	localparam int CTRL_ADDR_BIT = 8;
	localparam int CTRL_NDATA_LSB = 9;
	localparam int CTRL_ACCEL_BIT = 16;
	localparam int CTRL_GO_BIT = 31;
	localparam logic [2:0] ACCEL_DATA_BYTES = 3'h4;
	localparam logic [2:0] MAX_DATA_BYTES = 3'h4;

	// Commands that alter the device
	function automatic logic is_write_op(input logic [7:0] op);
		return op == OP_PP || op == OP_WREN || op == OP_WRSEC ||
			op == OP_ENTER_OTP || op == OP_EXIT_OTP;
	endfunction

	// Commands usable under accel voltage
	function automatic logic accel_op(input logic [7:0] op);
		return op == OP_RDSR || op == OP_PP;
	endfunction
endpackage

// *** core/otp_link_if.sv ***
// Purpose: serial command link between host controller and OTP device
// Assumes: host drives clock-like sck from its own clock
// Notes: all pins are one-way
`timescale 1ns/10ps
`default_nettype none
interface otp_link_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic accel_hv;
	modport dev (input cs_n, input sck, input mosi, input accel_hv, output miso);
	modport host (output cs_n, output sck, output mosi, output accel_hv, input miso);
endinterface
`default_nettype wire

// *** core/otp_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are levels
// Notes: first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module otp_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} otp_sync_st_t;
	otp_sync_st_t s;
	otp_sync_st_t n;

	// Shift pins through both stages
	always_comb begin
		n.s1 = d;
		n.s2 = s.s1;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.s2;
endmodule
`default_nettype wire

// *** core/otp_host.sv ***
// Purpose: host end; frames commands ordered over Wishbone
// Assumes: classic Wishbone master, one request at a time
// Notes: ack one cycle after request; write lands on ack edge
`timescale 1ns/10ps
`default_nettype none
module otp_host
	import otp_pkg::*;
#(
	parameter int PUW_WAIT_CYC = PUW_MAX_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_wr,
	output logic [31:0] wb_dat_rd,
	output logic wb_ack,
	otp_link_if.host link
);
	typedef enum logic [1:0] {H_IDLE, H_LO, H_HI, H_GAP} otp_hstate_t;
	typedef struct packed {
		otp_hstate_t state;
		logic [3:0] div;
		logic [63:0] tx;
		logic [7:0] rx;
		logic [6:0] nbits;
		logic cs_n;
		logic sck;
		logic mosi;
		logic accel;
		logic [9:0] settle;
		logic [19:0] pu_cnt;
		logic pu_done;
		logic [7:0] op;
		logic has_addr;
		logic [2:0] ndata;
		logic [23:0] addr;
		logic [31:0] wdata;
		logic busy;
		logic err;
		logic ack;
		logic [31:0] rdat;
	} otp_host_st_t;
	localparam otp_host_st_t HOST_RST = '{state: H_IDLE, cs_n: 1'b1, default: '0};

	otp_host_st_t s;
	otp_host_st_t n;
	logic miso_s;
	logic [31:0] w;
	logic [31:0] am;
	logic bad;

	otp_sync #(.W(1)) u_sync (
		.clock(clock),
		.srst(srst),
		.d(link.miso),
		.q(miso_s)
	);

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = v[8*i +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		n = s;
		n.ack = 1'b0;
		w = merge({15'h0, s.accel, 4'h0, s.ndata, s.has_addr, s.op}, wb_dat_wr, wb_sel);
		// Address register image; top byte is dropped on store
		am = merge({8'h0, s.addr}, wb_dat_wr, wb_sel);
		// Accel framing limits checked before anything is sent
		bad = w[CTRL_NDATA_LSB +: 3] > MAX_DATA_BYTES ||
			(w[CTRL_ACCEL_BIT] && (!accel_op(w[7:0]) || (w[7:0] == OP_PP &&
			(s.addr[1:0] != 2'h0 || w[CTRL_NDATA_LSB +: 3] != ACCEL_DATA_BYTES))));
		if (s.div != 4'h0) begin
			n.div = s.div - 4'h1;
		end
		if (s.settle != 10'h0) begin
			n.settle = s.settle - 10'h1;
		end
		if (!s.pu_done) begin
			n.pu_cnt = s.pu_cnt + 20'h1;
			if (s.pu_cnt == 20'(PUW_WAIT_CYC - 1)) begin
				n.pu_done = 1'b1;
			end
		end
		// Bus slave: read data registered with ack
		if (wb_cyc && wb_stb && !s.ack) begin
			n.ack = 1'b1;
			unique case (wb_adr)
				REG_CTRL: n.rdat = {15'h0, s.accel, 4'h0, s.ndata, s.has_addr, s.op};
				REG_ADDR: n.rdat = {8'h0, s.addr};
				REG_WDATA: n.rdat = s.wdata;
				REG_STAT: n.rdat = {16'h0, s.rx, 4'h0, s.settle == 10'h0, s.pu_done, s.err, s.busy};
				default: n.rdat = '0;
			endcase
		end
		if (wb_cyc && wb_stb && s.ack && wb_we) begin
			unique case (wb_adr)
				REG_CTRL: begin
					if (!s.busy) begin
						n.op = w[7:0];
						n.has_addr = w[CTRL_ADDR_BIT];
						n.ndata = w[CTRL_NDATA_LSB +: 3];
						if (w[CTRL_ACCEL_BIT] != s.accel) begin
							n.accel = w[CTRL_ACCEL_BIT];
							n.settle = 10'(ACCEL_SETTLE_CYC);
						end
						if (w[CTRL_GO_BIT]) begin
							n.err = bad;
							n.busy = !bad;
						end
					end
				end
				REG_ADDR: n.addr = am[23:0];
				REG_WDATA: n.wdata = merge(s.wdata, wb_dat_wr, wb_sel);
				default: begin
				end
			endcase
		end
		// Link sequencer; frames always end on a byte boundary
		unique case (s.state)
			H_IDLE: begin
				if (s.busy && s.settle == 10'h0 && (s.pu_done || !is_write_op(s.op))) begin
					n.tx = s.has_addr ? {s.op, s.addr, s.wdata} : {s.op, s.wdata, 24'h0};
					n.nbits = 7'(8 * (1 + (s.has_addr ? 3 : 0) + int'(s.ndata)));
					n.cs_n = 1'b0;
					n.mosi = s.op[7];
					n.div = SCK_HALF_CYC - 4'h1;
					n.state = H_LO;
				end
			end
			H_LO: begin
				if (s.div == 4'h0) begin
					n.sck = 1'b1;
					n.div = SCK_HALF_CYC - 4'h1;
					n.state = H_HI;
				end
			end
			H_HI: begin
				if (s.div == 4'h0) begin
					n.sck = 1'b0;
					n.rx = {s.rx[6:0], miso_s};
					n.tx = {s.tx[62:0], 1'b0};
					n.nbits = s.nbits - 7'h1;
					n.div = SCK_HALF_CYC - 4'h1;
					n.mosi = s.tx[62];
					n.state = (s.nbits == 7'h1) ? H_GAP : H_LO;
				end
			end
			H_GAP: begin
				if (s.div == 4'h0) begin
					if (!s.cs_n) begin
						n.cs_n = 1'b1;
						n.div = SCK_HALF_CYC - 4'h1;
					end else begin
						n.busy = 1'b0;
						n.state = H_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s <= HOST_RST;
		end else begin
			s <= n;
		end
	end

	assign wb_ack = s.ack;
	assign wb_dat_rd = s.rdat;
	assign link.cs_n = s.cs_n;
	assign link.sck = s.sck;
	assign link.mosi = s.mosi;
	assign link.accel_hv = s.accel;
endmodule
`default_nettype wire

// *** verif/otp_link_asserts.sv ***
// Purpose: link and device status checks for the OTP lock control
// Assumes: one clock, srst synchronous active high
// Notes: sees link pins and device status flags only
`timescale 1ns/10ps
`default_nettype none
module otp_link_asserts
	import otp_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic accel_hv,
	input wire logic otp_mode,
	input wire logic cust_lock,
	input wire logic fact_lock,
	input wire logic write_inhibit,
	input wire logic cmd_rejected,
	input wire logic main_wr
);
	// Two cycles of slack for the host's own flops
	localparam int SETTLE_MIN = ACCEL_SETTLE_CYC - 2;
	int settle_ff;
	logic accel_q_ff;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	// Cycles since accel level moved; saturates so idle frames pass
	always_ff @(posedge clock) begin
		accel_q_ff <= accel_hv;
		if (srst) begin
			settle_ff <= ACCEL_SETTLE_CYC;
		end else if (accel_hv != accel_q_ff) begin
			settle_ff <= 0;
		end else if (settle_ff < ACCEL_SETTLE_CYC) begin
			settle_ff <= settle_ff + 1;
		end
	end
	property p_settle;
		$fell(cs_n) |-> settle_ff >= SETTLE_MIN;
	endproperty
	a_settle: assert property (p_settle) else $error("frame too soon after accel change");
	property p_otp_main;
		otp_mode |-> !main_wr;
	endproperty
	a_otp_main: assert property (p_otp_main) else $error("main write in OTP mode");
	property p_inh_main;
		write_inhibit |-> !main_wr;
	endproperty
	a_inh_main: assert property (p_inh_main) else $error("main write while inhibited");
	property p_inh_sticky;
		!write_inhibit |=> !write_inhibit;
	endproperty
	a_inh_sticky: assert property (p_inh_sticky) else $error("inhibit came back");
	property p_cust_sticky;
		cust_lock |=> cust_lock;
	endproperty
	a_cust_sticky: assert property (p_cust_sticky) else $error("customer lock cleared");
	property p_fact;
		$stable(fact_lock);
	endproperty
	a_fact: assert property (p_fact) else $error("factory lock moved");
	property p_lock_cs;
		$rose(cust_lock) |-> cs_n && !write_inhibit;
	endproperty
	a_lock_cs: assert property (p_lock_cs) else $error("lock set mid frame");
	property p_mode_cs;
		$changed(otp_mode) |-> cs_n;
	endproperty
	a_mode_cs: assert property (p_mode_cs) else $error("mode moved mid frame");
	property p_sck_idle;
		cs_n && $past(cs_n) |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck high while idle");
	property p_rej_pulse;
		cmd_rejected |=> !cmd_rejected;
	endproperty
	a_rej_pulse: assert property (p_rej_pulse) else $error("reject not a pulse");
	c_lock: cover property ($rose(cust_lock));
	c_mode: cover property ($rose(otp_mode));
	c_main: cover property (main_wr);
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: both ends joined; Wishbone orders drive OTP lock scenarios
// Assumes: host ack one cycle after request, STAT.busy polled
// Notes: short power-up counts keep the run brief
`timescale 1ns/10ps
`default_nettype none
module testbench
	import otp_pkg::*;
;
	logic clock;
	logic srst;
	logic wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_wr, wb_dat_rd, rd;
	logic otp_mode, cust_lock, fact_lock, write_inhibit, cmd_rejected, main_wr;
	logic [23:0] main_addr, mw_addr;
	logic [7:0] main_data, mw_data;
	int rej_cnt = 0;
	int mw_cnt = 0;
	int r0, n;
	int fail_count = 0;
	int tests_run = 0;
	otp_link_if link ();
	otp_dev #(.PUW_CYC(50), .FACTORY_LOCKED(1'b0)) i_otp_dev (.clock(clock), .srst(srst),
		.link(link), .otp_mode(otp_mode), .cust_lock(cust_lock), .fact_lock(fact_lock),
		.write_inhibit(write_inhibit), .cmd_rejected(cmd_rejected), .main_wr(main_wr),
		.main_addr(main_addr), .main_data(main_data));
	otp_host #(.PUW_WAIT_CYC(60)) i_otp_host (.clock(clock), .srst(srst), .wb_cyc(wb_cyc),
		.wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .link(link));
	otp_link_asserts i_otp_link_asserts (.clock(clock), .srst(srst), .cs_n(link.cs_n),
		.sck(link.sck), .accel_hv(link.accel_hv), .otp_mode(otp_mode),
		.cust_lock(cust_lock), .fact_lock(fact_lock), .write_inhibit(write_inhibit),
		.cmd_rejected(cmd_rejected), .main_wr(main_wr));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Pulses are counted, so checks never miss a one-cycle flag
	always @(posedge clock) begin
		if (cmd_rejected === 1'b1) begin
			rej_cnt++;
		end
		if (main_wr === 1'b1) begin
			mw_cnt++;
			mw_addr <= main_addr;
			mw_data <= main_data;
		end
	end
	task automatic report_and_stop();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One classic cycle; request held until ack is sampled
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		@(posedge clock);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_wr <= dat;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (wb_ack !== 1'b1 && k < 50);
		rd = wb_dat_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (wb_ack !== 1'b1) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	// Frame one command, then poll until busy clears
	task automatic cmd(input logic [7:0] op, input logic ha, input logic [2:0] nd,
		input logic acc, input logic [23:0] a, input logic [31:0] d);
		int k;
		wb_xfer(1'b1, REG_ADDR, {8'h00, a});
		wb_xfer(1'b1, REG_WDATA, d);
		wb_xfer(1'b1, REG_CTRL, {1'b1, 14'h0, acc, 4'h0, nd, ha, op});
		k = 0;
		do begin
			wb_xfer(1'b0, REG_STAT, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 1000);
		if (rd[0] !== 1'b0) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic rdb(input logic [7:0] op, input logic ha, input logic [23:0] a,
		input logic [7:0] exp);
		cmd(op, ha, 3'h1, 1'b0, a, 32'h0);
		chk({24'h0, rd[15:8]}, {24'h0, exp});
	endtask
	task automatic pp(input logic [23:0] a, input logic [7:0] d);
		cmd(OP_WREN, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		cmd(OP_PP, 1'b1, 3'h1, 1'b0, a, {d, 24'h0});
	endtask
	initial begin
		srst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hf;
		wb_dat_wr = 32'h0;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1;
		chk({31'h0, write_inhibit}, 32'h1);
		chk({31'h0, fact_lock}, 32'h0);
		n = 0;
		do begin
			wb_xfer(1'b0, REG_STAT, 32'h0);
			n++;
		end while (rd[2] !== 1'b1 && n < 100);
		chk({31'h0, write_inhibit}, 32'h0);
		rdb(OP_RDSR, 1'b0, 24'h0, 8'h00);
		rdb(OP_RDSEC, 1'b0, 24'h0, 8'h00);
		// Three-byte security write must be refused whole
		r0 = rej_cnt;
		cmd(OP_WRSEC, 1'b0, 3'h2, 1'b0, 24'h0, 32'h0202_0000);
		chk({31'h0, rej_cnt != r0}, 32'h1);
		chk({31'h0, cust_lock}, 32'h0);
		cmd(OP_ENTER_OTP, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		chk({31'h0, otp_mode}, 32'h1);
		r0 = mw_cnt;
		pp(24'h000010, 8'h5a);
		pp(24'h00000f, 8'h3c);
		rdb(OP_READ, 1'b1, 24'h000010, 8'h5a);
		rdb(OP_READ, 1'b1, 24'h00000f, 8'h3c);
		rdb(OP_READ, 1'b1, 24'h000011, 8'hff);
		chk(32'(mw_cnt - r0), 32'h0);
		cmd(OP_EXIT_OTP, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		chk({31'h0, otp_mode}, 32'h0);
		// Lock with no write enable; bit0 in the byte must be ignored
		rdb(OP_RDSR, 1'b0, 24'h0, 8'h00);
		cmd(OP_WRSEC, 1'b0, 3'h1, 1'b0, 24'h0, 32'h0300_0000);
		chk({31'h0, cust_lock}, 32'h1);
		rdb(OP_RDSEC, 1'b0, 24'h0, 8'h02);
		cmd(OP_WRSEC, 1'b0, 3'h1, 1'b0, 24'h0, 32'h0);
		rdb(OP_RDSEC, 1'b0, 24'h0, 8'h02);
		cmd(OP_ENTER_OTP, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		r0 = rej_cnt;
		pp(24'h000020, 8'h5a);
		chk({31'h0, rej_cnt != r0}, 32'h1);
		rdb(OP_READ, 1'b1, 24'h000020, 8'hff);
		cmd(OP_EXIT_OTP, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		r0 = mw_cnt;
		pp(24'h000100, 8'ha5);
		chk(32'(mw_cnt - r0), 32'h1);
		chk({mw_addr, mw_data}, 32'h0001_00a5);
		// Misaligned accel start and short accel data are stopped in the host
		cmd(OP_WREN, 1'b0, 3'h0, 1'b0, 24'h0, 32'h0);
		cmd(OP_PP, 1'b1, 3'h4, 1'b1, 24'h000102, 32'h0);
		chk({31'h0, rd[1]}, 32'h1);
		cmd(OP_PP, 1'b1, 3'h2, 1'b1, 24'h000104, 32'h0);
		chk({31'h0, rd[1]}, 32'h1);
		// Aligned accel program rides on the earlier write enable
		r0 = mw_cnt;
		cmd(OP_PP, 1'b1, 3'h4, 1'b1, 24'h000104, 32'h1122_3344);
		chk({31'h0, rd[1]}, 32'h0);
		chk(32'(mw_cnt - r0), 32'h4);
		chk({mw_addr, mw_data}, 32'h0001_0744);
		cmd(OP_RDSR, 1'b0, 3'h1, 1'b1, 24'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h0);
		// Write enable was used up, so the device refuses this one
		r0 = rej_cnt;
		cmd(OP_PP, 1'b1, 3'h4, 1'b1, 24'h000108, 32'h0);
		chk({31'h0, rej_cnt != r0}, 32'h1);
		cmd(OP_RDSEC, 1'b0, 3'h1, 1'b1, 24'h0, 32'h0);
		chk({31'h0, rd[1]}, 32'h1);
		wb_xfer(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		wb_xfer(1'b0, REG_CTRL, 32'h0);
		chk({31'h0, rd[CTRL_GO_BIT]}, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
